// >>> acc_alu.sv
/*
  Combinational ALU: result plus carry, nibble carry and zero.
  Assumes operands come from the same clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
`include "acc_flags_defs.svh"
module acc_alu
  import acc_flags_pkg::*;
(
  input wire acc_flags_pkg::alu_op_t op_i,
  input wire acc_flags_pkg::byte_t a_i,
  input wire acc_flags_pkg::byte_t b_i,
  input wire logic carry_i,
  output acc_flags_pkg::byte_t res_o,
  output logic carry_o,
  output logic nibble_o,
  output logic zero_o,
  output logic carry_upd_o,
  output logic nibble_upd_o
);
  function automatic logic [8:0] add9(input byte_t a, input byte_t b, input logic ci);
    add9 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
  endfunction

  function automatic logic [4:0] add5(input logic [3:0] a, input logic [3:0] b, input logic ci);
    add5 = {1'b0, a} + {1'b0, b} + {4'h0, ci};
  endfunction

  always_comb begin
    logic [8:0] s9;
    logic [4:0] s5;
    s9 = 9'h000;
    s5 = 5'h00;
    res_o = a_i;
    carry_o = carry_i;
    nibble_o = 1'b0;
    carry_upd_o = 1'b0;
    nibble_upd_o = 1'b0;
    unique case (op_i)
      `OP_ADD, `OP_ADC: begin
        s9 = add9(a_i, b_i, (op_i == `OP_ADC) & carry_i);
        s5 = add5(a_i[3:0], b_i[3:0], (op_i == `OP_ADC) & carry_i);
        res_o = s9[7:0];
        carry_o = s9[8];
        nibble_o = s5[4];
        carry_upd_o = 1'b1;
        nibble_upd_o = 1'b1;
      end
      // Subtract as a + ~b + 1, SBC as a + ~b + carry; carry out high means no borrow
      `OP_SUB, `OP_SBC, `OP_CMP: begin
        s9 = add9(a_i, ~b_i, (op_i == `OP_SBC) ? carry_i : 1'b1);
        s5 = add5(a_i[3:0], ~b_i[3:0], (op_i == `OP_SBC) ? carry_i : 1'b1);
        res_o = s9[7:0];
        carry_o = s9[8];
        nibble_o = s5[4];
        carry_upd_o = 1'b1;
        nibble_upd_o = (op_i != `OP_CMP);
      end
      `OP_AND: res_o = a_i & b_i;
      `OP_OR: res_o = a_i | b_i;
      `OP_XOR: res_o = a_i ^ b_i;
      `OP_RRC: begin
        res_o = {carry_i, b_i[7:1]};
        carry_o = b_i[0];
        carry_upd_o = 1'b1;
      end
      `OP_RLC: begin
        res_o = {b_i[6:0], carry_i};
        carry_o = b_i[7];
        carry_upd_o = 1'b1;
      end
      `OP_LOAD: res_o = b_i;
      `OP_INC: res_o = b_i + 8'h01;
      `OP_DEC: res_o = b_i - 8'h01;
      default: res_o = a_i;
    endcase
    zero_o = (res_o == 8'h00);
  end
endmodule
`default_nettype wire

// >>> acc_flags_defs.svh
/*
  Constants for the accumulator and status flag block: data address,
  field positions, reset cause codes, local register offsets, ALU opcodes.
  Assumes nothing; definitions only.
*/
`ifndef ACC_FLAGS_DEFS_SVH
`define ACC_FLAGS_DEFS_SVH

`define STATUS_ADDR 8'h86
`define IRQ_STAT_ADDR 8'h90
`define IRQ_MASK_ADDR 8'h91
`define ACC_VIEW_ADDR 8'h92

`define BIT_CAUSE_HI 7
`define BIT_CAUSE_LO 6
`define BIT_SUP_HIGH 5
`define BIT_SUP_MID 4
`define BIT_UNUSED 3
`define BIT_CARRY 2
`define BIT_NIBBLE 1
`define BIT_ZERO 0

`define CAUSE_WATCHDOG 2'h0
`define CAUSE_LOW_VOLT 2'h2
`define CAUSE_PIN_POR 2'h3

`define FLAGS_RW_MASK 8'hc7
`define SAVE_MASK 8'h3f

`define EVT_ZERO 0
`define EVT_CARRY 1
`define EVT_LOWV 2
`define EVT_WIDTH 3

`define OP_ADD 4'h0
`define OP_ADC 4'h1
`define OP_SUB 4'h2
`define OP_SBC 4'h3
`define OP_AND 4'h4
`define OP_OR 4'h5
`define OP_XOR 4'h6
`define OP_RRC 4'h7
`define OP_RLC 4'h8
`define OP_CMP 4'h9
`define OP_LOAD 4'ha
`define OP_INC 4'hb
`define OP_DEC 4'hc

`endif

// >>> acc_flags_pkg.sv
/*
  Types for the accumulator and status flag block.
  Assumes acc_flags_defs.svh is on the include path.
*/
`include "acc_flags_defs.svh"
package acc_flags_pkg;
  typedef logic [3:0] alu_op_t;
  typedef logic [7:0] byte_t;

  typedef enum logic [2:0] {
    CAUSE_IDLE = 3'h1,
    CAUSE_CAPTURE = 3'h2,
    CAUSE_RUN = 3'h4
  } cause_state_e;
endpackage

// >>> acc_status_core.sv
/*
  Accumulator and program status flag register with a one-deep save
  buffer, reset cause capture, supply detect flags and an interrupt.
  Assumes the core drives op strobes on clk_i; cause and supply inputs
  are asynchronous levels, cause latched once after reset release.
*/
// The plain strobed port is this design's own decision.
// What this block does
// - Eight-bit accumulator between ALU and memory
// - ALU operations update zero; add and subtract also carry and nibble carry, compare and shifts carry only
// - Accumulator has no data memory address
// - Interrupt entry leaves accumulator and flags untouched
// - Save copies both; restore reloads both
// - One level save, reset cause excluded
// - Status register at 0x86 with fixed layout
// - Reset cause coded watchdog, low-voltage, pin
// - Bit 5 shows supply at or below high
// - Bit 4 shows supply at or below mid
// - Carry set by carry, no-borrow, shift, compare
// - Nibble carry on low-nibble carry or no-borrow
// - Zero flag follows result being zero
`timescale 1ns/1ns
`default_nettype none
`include "acc_flags_defs.svh"
module acc_status_core
  import acc_flags_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [1:0] reset_cause_i,
  input wire logic supply_detect_high_option_i,
  input wire logic supply_detect_mid_option_i,
  input wire logic supply_below_high_i,
  input wire logic supply_below_mid_i,
  input wire logic alu_valid_i,
  input wire acc_flags_pkg::alu_op_t alu_op_i,
  input wire acc_flags_pkg::byte_t alu_operand_i,
  input wire logic acc_write_i,
  input wire acc_flags_pkg::byte_t acc_wdata_i,
  input wire logic push_i,
  input wire logic pop_i,
  input wire logic irq_entry_i,
  input wire logic [7:0] addr_i,
  input wire acc_flags_pkg::byte_t wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output acc_flags_pkg::byte_t rdata_o,
  output acc_flags_pkg::byte_t working_accumulator_o,
  output acc_flags_pkg::byte_t alu_result_o,
  output logic alu_result_valid_o,
  output acc_flags_pkg::byte_t program_status_flags_o,
  output logic irq_o
);
  import acc_flags_pkg::*;

  typedef struct packed {
    cause_state_e cst;
    logic cause_wait;
    byte_t acc;
    logic [1:0] cause;
    logic [2:0] alu_flags;
    byte_t save_acc;
    logic [2:0] save_flags;
    logic [`EVT_WIDTH-1:0] irq_stat;
    logic [`EVT_WIDTH-1:0] irq_mask;
    logic [1:0] sup_prev;
    byte_t rdata;
    byte_t res;
    logic res_valid;
    byte_t flags_out;
    logic irq;
  } state_s;

  state_s s_q, s_d;
  logic [1:0] sup_sync, cause_sync;
  byte_t alu_res;
  logic alu_c, alu_n, alu_z, c_upd, n_upd;

  acc_supply_sync u_sup_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .async_i({supply_below_high_i, supply_below_mid_i}),
    .sync_o(sup_sync)
  );

  acc_supply_sync u_cause_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .async_i(reset_cause_i),
    .sync_o(cause_sync)
  );

  acc_alu u_alu (
    .op_i(alu_op_i),
    .a_i(s_q.acc),
    .b_i(alu_operand_i),
    .carry_i(s_q.alu_flags[`BIT_CARRY]),
    .res_o(alu_res),
    .carry_o(alu_c),
    .nibble_o(alu_n),
    .zero_o(alu_z),
    .carry_upd_o(c_upd),
    .nibble_upd_o(n_upd)
  );

  // Assemble the status byte; supply bits show only under their build option
  function automatic byte_t status_byte(input logic [1:0] cause, input logic [1:0] sup,
                                        input logic [2:0] fl);
    byte_t b;
    b = 8'h00;
    b[`BIT_CAUSE_HI] = cause[1];
    b[`BIT_CAUSE_LO] = cause[0];
    b[`BIT_SUP_HIGH] = sup[1] & supply_detect_high_option_i;
    b[`BIT_SUP_MID] = sup[0] & supply_detect_mid_option_i;
    b[`BIT_UNUSED] = 1'b0;
    b[`BIT_CARRY] = fl[`BIT_CARRY];
    b[`BIT_NIBBLE] = fl[`BIT_NIBBLE];
    b[`BIT_ZERO] = fl[`BIT_ZERO];
    status_byte = b;
  endfunction

  always_comb begin
    logic [`EVT_WIDTH-1:0] evt;
    logic [2:0] fl;
    byte_t cur;
    evt = '0;
    s_d = s_q;
    fl = s_q.alu_flags;
    cur = status_byte(s_q.cause, sup_sync, s_q.alu_flags);
    s_d.sup_prev = sup_sync;
    s_d.res_valid = 1'b0;

    // Cause is latched once, after the synchroniser has filled, since async reset may not sample ports
    unique case (s_q.cst)
      CAUSE_IDLE: begin
        s_d.cause_wait = 1'b1;
        if (s_q.cause_wait) s_d.cst = CAUSE_CAPTURE;
      end
      CAUSE_CAPTURE: begin
        s_d.cause = cause_sync;
        s_d.cst = CAUSE_RUN;
      end
      CAUSE_RUN: s_d.cst = CAUSE_RUN;
    endcase

    // irq_entry_i is deliberately unused for state: nothing is saved on entry
    if (pop_i) begin
      s_d.acc = s_q.save_acc;
      fl = s_q.save_flags;
    end else if (alu_valid_i) begin
      s_d.acc = alu_res;
      s_d.res = alu_res;
      s_d.res_valid = 1'b1;
      fl[`BIT_ZERO] = alu_z;
      if (c_upd) fl[`BIT_CARRY] = alu_c;
      if (n_upd) fl[`BIT_NIBBLE] = alu_n;
      evt[`EVT_ZERO] = alu_z;
      evt[`EVT_CARRY] = c_upd & alu_c;
    end else if (acc_write_i) begin
      s_d.acc = acc_wdata_i;
    end
    if (push_i) begin
      s_d.save_acc = s_q.acc;
      s_d.save_flags = s_q.alu_flags;
    end

    // Register bus; the accumulator itself has no address here
    if (wr_i && addr_i == `STATUS_ADDR) begin
      fl = wdata_i[2:0];
      s_d.cause = {wdata_i[`BIT_CAUSE_HI], wdata_i[`BIT_CAUSE_LO]};
    end
    s_d.alu_flags = fl;

    evt[`EVT_LOWV] = |(sup_sync & ~s_q.sup_prev);
    s_d.irq_stat = s_q.irq_stat;
    if (wr_i && addr_i == `IRQ_STAT_ADDR) s_d.irq_stat = s_q.irq_stat & ~wdata_i[`EVT_WIDTH-1:0];
    if (wr_i && addr_i == `IRQ_MASK_ADDR) s_d.irq_mask = wdata_i[`EVT_WIDTH-1:0];
    s_d.irq_stat = s_d.irq_stat | evt;

    s_d.rdata = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        `STATUS_ADDR: s_d.rdata = cur;
        `IRQ_STAT_ADDR: s_d.rdata = {5'h00, s_q.irq_stat};
        `IRQ_MASK_ADDR: s_d.rdata = {5'h00, s_q.irq_mask};
        default: s_d.rdata = 8'h00;
      endcase
    end
    s_d.flags_out = status_byte(s_d.cause, sup_sync, s_d.alu_flags);
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q <= '0;
      s_q.cst <= CAUSE_IDLE;
      s_q.cause <= `CAUSE_PIN_POR;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rdata;
  assign working_accumulator_o = s_q.acc;
  assign alu_result_o = s_q.res;
  assign alu_result_valid_o = s_q.res_valid;
  assign program_status_flags_o = s_q.flags_out;
  assign irq_o = s_q.irq;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence alu_zero_op;
    alu_valid_i && !pop_i && !(wr_i && addr_i == `STATUS_ADDR) && alu_res == 8'h00;
  endsequence

  a_zero_flag_set: assert property (alu_zero_op |=> program_status_flags_o[`BIT_ZERO])
    else $error("zero flag not set after zero result");
  a_acc_takes_alu: assert property (alu_valid_i && !pop_i |=> working_accumulator_o == $past(alu_res))
    else $error("accumulator missed ALU result");
  a_push_pop_pair: assert property (pop_i
      |=> working_accumulator_o == $past(s_q.save_acc))
    else $error("pop did not restore accumulator");
  a_pop_keeps_cause: assert property (pop_i && s_q.cst == CAUSE_RUN && !(wr_i && addr_i == `STATUS_ADDR)
      |=> s_q.cause == $past(s_q.cause))
    else $error("pop changed reset cause");
  a_irq_entry_quiet: assert property (irq_entry_i && !alu_valid_i && !pop_i && !acc_write_i
      |=> $stable(s_q.acc))
    else $error("interrupt entry changed accumulator");
  a_unused_bit_zero: assert property (!program_status_flags_o[`BIT_UNUSED])
    else $error("unused status bit set");
  a_sup_option_gate: assert property (!supply_detect_high_option_i ##1 !supply_detect_high_option_i
      |-> !program_status_flags_o[`BIT_SUP_HIGH])
    else $error("high supply flag without option");
  a_mid_option_gate: assert property (!supply_detect_mid_option_i ##1 !supply_detect_mid_option_i
      |-> !program_status_flags_o[`BIT_SUP_MID])
    else $error("mid supply flag without option");
  a_carry_on_add: assert property (alu_valid_i && !pop_i && alu_op_i == `OP_ADD && !wr_i
      |=> program_status_flags_o[`BIT_CARRY] == $past(alu_c))
    else $error("carry wrong after add");
  a_nibble_on_add: assert property (alu_valid_i && !pop_i && alu_op_i == `OP_ADD && !wr_i
      |=> program_status_flags_o[`BIT_NIBBLE] == $past(alu_n))
    else $error("nibble carry wrong after add");
  a_status_read: assert property (rd_i && addr_i == `STATUS_ADDR |=> rdata_o[`BIT_UNUSED] == 1'b0)
    else $error("status read wrong");
endmodule
`default_nettype wire

// >>> acc_supply_sync.sv
/*
  Two-stage synchroniser for the supply detector levels.
  Assumes the detector outputs are asynchronous levels.
*/
`timescale 1ns/1ns
`default_nettype none
module acc_supply_sync (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [1:0] async_i,
  output logic [1:0] sync_o
);
  logic [1:0] meta_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= 2'h0;
      sync_o <= 2'h0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

// >>> accumulator_status_flags_tb.sv
/*
  Self-checking testbench for acc_status_core: reset cause, ALU flags,
  status register port, save buffer, supply flags and interrupt.
  Assumes acc_flags_pkg is compiled first and acc_flags_defs.svh is on the include path.
*/
`timescale 1ns/1ns
`default_nettype none
`include "acc_flags_defs.svh"
module accumulator_status_flags_tb;
  import acc_flags_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [1:0] cause = 2'h3;
  logic opt_h = 1'b0, opt_m = 1'b0, below_h = 1'b0, below_m = 1'b0;
  logic alu_valid = 1'b0, acc_wr = 1'b0, wr = 1'b0, rd = 1'b0, res_v, irq;
  logic [2:0] ctl = 3'h0;
  alu_op_t op = 4'h0;
  byte_t operand = 8'h00, acc_d = 8'h00, addr = 8'h00, wdata = 8'h00;
  byte_t rdata, acc, res, flags, v;
  logic [1:0] causes [3] = '{`CAUSE_WATCHDOG, `CAUSE_LOW_VOLT, `CAUSE_PIN_POR};
  // Row order matters: RRC, RLC, ADC and SBC consume the carry left by the row before
  alu_op_t to [16] = '{`OP_ADD, `OP_ADD, `OP_SUB, `OP_SUB, `OP_RRC, `OP_RLC, `OP_CMP, `OP_ADC,
                       `OP_SBC, `OP_AND, `OP_OR, `OP_XOR, `OP_LOAD, `OP_INC, `OP_DEC, `OP_CMP};
  byte_t ta [16] = '{8'h0f, 8'hf0, 8'h10, 8'h01, 8'h01, 8'h80, 8'h05, 8'h0e,
                     8'h05, 8'hf0, 8'hf0, 8'hff, 8'h12, 8'hff, 8'h01, 8'h03};
  // Rotate, increment and decrement work on the operand, not the accumulator
  byte_t tb [16] = '{8'h01, 8'h10, 8'h01, 8'h02, 8'h01, 8'h80, 8'h05, 8'h01,
                     8'h01, 8'h0f, 8'h0f, 8'hff, 8'h00, 8'hff, 8'h01, 8'h04};
  byte_t tr [16] = '{8'h10, 8'h00, 8'h0f, 8'hff, 8'h00, 8'h01, 8'h00, 8'h10,
                     8'h03, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff};
  byte_t tm [16] = '{8'h07, 8'h07, 8'h07, 8'h07, 8'h04, 8'h04, 8'h05, 8'h07,
                     8'h07, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h05};
  byte_t tv [16] = '{8'h02, 8'h05, 8'h04, 8'h00, 8'h04, 8'h04, 8'h05, 8'h02,
                     8'h06, 8'h01, 8'h00, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00};
  int n_mismatch = 0;
  int tests_run = 0;
  logic irq0;

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  acc_status_core dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .reset_cause_i(cause),
    .supply_detect_high_option_i(opt_h), .supply_detect_mid_option_i(opt_m),
    .supply_below_high_i(below_h), .supply_below_mid_i(below_m),
    .alu_valid_i(alu_valid), .alu_op_i(op), .alu_operand_i(operand),
    .acc_write_i(acc_wr), .acc_wdata_i(acc_d), .push_i(ctl[0]), .pop_i(ctl[1]),
    .irq_entry_i(ctl[2]), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .working_accumulator_o(acc), .alu_result_o(res),
    .alu_result_valid_o(res_v), .program_status_flags_o(flags), .irq_o(irq)
  );

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input byte_t exp, input byte_t got);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask

  // Every task ends one idle edge after dropping its strobe, so calls may follow directly
  task automatic wr_reg(input byte_t a, input byte_t d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic chk_reg(input string what, input byte_t a, input byte_t exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    chk(what, exp, rdata);
    @(posedge clk_i);
  endtask

  task automatic strobe(input logic [2:0] c);
    ctl <= c;
    @(posedge clk_i);
    ctl <= 3'h0;
    @(posedge clk_i);
  endtask

  task automatic load(input byte_t d);
    acc_d <= d;
    acc_wr <= 1'b1;
    @(posedge clk_i);
    acc_wr <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic alu(input alu_op_t o, input byte_t b);
    op <= o;
    operand <= b;
    alu_valid <= 1'b1;
    @(posedge clk_i);
    alu_valid <= 1'b0;
    #1;
    chk("result valid", 8'h01, {7'h0, res_v});
    @(posedge clk_i);
  endtask

  task automatic do_reset();
    rstn_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    complete_run();
  end

  initial begin
    for (int i = 0; i < 3; i++) begin
      cause <= causes[i];
      do_reset();
      chk_reg("status after reset", `STATUS_ADDR, {causes[i], 6'h00});
    end
    chk("irq after reset", 8'h00, {7'h0, irq});
    $display("test reset cause done");
    for (int i = 0; i < 16; i++) begin
      load(ta[i]);
      chk("accumulator load", ta[i], acc);
      alu(to[i], tb[i]);
      chk("alu result", tr[i], res);
      chk("accumulator", tr[i], acc);
      chk("alu flags", tv[i], flags & tm[i]);
    end
    $display("test alu flags done");
    wr_reg(`STATUS_ADDR, 8'hff);
    chk_reg("status write ones", `STATUS_ADDR, 8'hc7);
    wr_reg(`STATUS_ADDR, 8'h00);
    chk_reg("status write zeros", `STATUS_ADDR, 8'h00);
    load(8'h44);
    wr_reg(8'h87, 8'haa);
    chk_reg("unmapped read", 8'h87, 8'h00);
    chk("accumulator after unmapped", 8'h44, acc);
    $display("test register port done");
    wr_reg(`STATUS_ADDR, 8'hc5);
    load(8'h5a);
    strobe(3'h1);
    wr_reg(`STATUS_ADDR, 8'hc2);
    load(8'h33);
    strobe(3'h1);
    wr_reg(`STATUS_ADDR, 8'h01);
    load(8'h77);
    strobe(3'h4);
    chk("accumulator after entry", 8'h77, acc);
    chk("status after entry", 8'h01, flags);
    strobe(3'h2);
    chk("accumulator after pop", 8'h33, acc);
    chk("status after pop", 8'h02, flags);
    strobe(3'h2);
    chk("accumulator second pop", 8'h33, acc);
    $display("test save buffer done");
    opt_h <= 1'b1;
    opt_m <= 1'b1;
    below_h <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk_reg("supply high flag", `STATUS_ADDR, 8'h22);
    below_m <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk_reg("supply both flags", `STATUS_ADDR, 8'h32);
    opt_h <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk_reg("high option off", `STATUS_ADDR, 8'h12);
    opt_m <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk_reg("mid option off", `STATUS_ADDR, 8'h02);
    below_h <= 1'b0;
    below_m <= 1'b0;
    $display("test supply flags done");
    wr_reg(`IRQ_MASK_ADDR, 8'h00);
    wr_reg(`IRQ_STAT_ADDR, 8'hff);
    chk_reg("irq status cleared", `IRQ_STAT_ADDR, 8'h00);
    chk("irq cleared", 8'h00, {7'h0, irq});
    load(8'h01);
    alu(`OP_DEC, 8'h01);
    chk_reg("zero event", `IRQ_STAT_ADDR, 8'h01);
    irq0 = irq;
    wr_reg(`IRQ_MASK_ADDR, 8'h07);
    chk("mask changes irq", 8'h01, {7'h0, irq0 ^ irq});
    wr_reg(`IRQ_STAT_ADDR, 8'h07);
    chk_reg("irq status after clear", `IRQ_STAT_ADDR, 8'h00);
    chk("irq after clear", 8'h00, {7'h0, irq});
    $display("test interrupt done");
    complete_run();
  end
endmodule
`default_nettype wire
